// ===== jtb_consts.vh
/*
 * Constants of the test access port: instruction codes, scan lengths,
 * boundary chain positions and flash register layout.
 * Assumes inclusion by bare name from files of the jtb block.
 */
`ifndef JTB_CONSTS_VH
`define JTB_CONSTS_VH

`define JTB_IR_W 16
`define JTB_IR_RESET 16'h0000
`define JTB_IR_CAPTURE 16'h0001
`define JTB_IR_EXTEST 16'h0000
`define JTB_IR_SAMPLE 16'h0002
`define JTB_IR_IDCODE 16'h0004
`define JTB_IR_BYPASS 16'hffff
`define JTB_IR_FLCTRL 16'h0082
`define JTB_IR_FLDATA 16'h0083
`define JTB_IR_FLADDR 16'h0084
`define JTB_IR_FLSCALE 16'h0085

`define JTB_LEN_BS 7'd87
`define JTB_LEN_ID 7'd32
`define JTB_LEN_FLASH 7'd20
`define JTB_LEN_BYP 7'd1

`define JTB_BS_RSTOE 0
`define JTB_BS_RSTPIN 1
`define JTB_BS_XTAL 2
`define JTB_BS_PULLUP 3
`define JTB_BS_ADDR_LO 4
`define JTB_BS_ADDR_HI 11
`define JTB_BS_DATA_LO 12
`define JTB_BS_DATA_HI 19
`define JTB_BS_WR 20
`define JTB_BS_RD 21
`define JTB_BS_RMW 22
`define JTB_BS_PORT0 23
`define JTB_PORT_PINS 32

`define JTB_FL_OP_HI 19
`define JTB_FL_OP_LO 18
`define JTB_FL_OP_WRITE 2'b11
`define JTB_FL_WD_HI 17

`define JTB_SYNC_W 37

`endif

// ===== jtb_pin_sync.v
/*
 * Two-stage synchroniser for a group of levels from outside ref_clk.
 * Assumes each bit is a slow level or a clock far below ref_clk.
 */
`timescale 1ns/10ps
module jtb_pin_sync #(
    parameter W = 1
) (
    input wire ref_clk,
    input wire rstn,
    input wire [W-1:0] asyncIn,
    output reg [W-1:0] syncOut_q
);
    reg [W-1:0] meta_q;

    // first stage feeds nothing but the second
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= {W{1'b0}};
            syncOut_q <= {W{1'b0}};
        end else begin
            meta_q <= asyncIn;
            syncOut_q <= meta_q;
        end
    end
endmodule // jtb_pin_sync

// ===== jtb_tap_core.v
/*
 * Test access port with instruction register, boundary scan chain,
 * bypass, identification and four flash-access data registers.
 * Assumes tck, tms, tdi and all pins are asynchronous to ref_clk and
 * tck runs well below a quarter of ref_clk; core-side signals are on ref_clk.
 */
`timescale 1ns/10ps
`include "jtb_consts.vh"
module jtb_tap_core #(
    parameter [31:0] ID_VALUE = 32'h00000001, // arbitrary value, lsb one as usual
    parameter FLASH_ADDR_W = 16
) (
    input wire ref_clk,
    input wire rstn,
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo_q,
    output reg tdoOe_n_q,
    input wire rstPinIn,
    output reg rstPinOut_q,
    output reg rstPinOe_n_q,
    input wire xtalPinIn,
    input wire [31:0] portPinIn,
    output reg [31:0] portPinOut_q,
    output reg [31:0] portPinOe_n_q,
    input wire coreRstDriveEn,
    input wire corePullupEn,
    input wire [31:0] corePortOut,
    input wire [31:0] corePortOe,
    input wire [7:0] coreBusAddr,
    input wire [7:0] coreBusWrData,
    input wire coreBusWr,
    input wire coreBusRd,
    input wire coreBusRmw,
    input wire [7:0] busRdData,
    output reg pullupEn_q,
    output reg [7:0] busAddr_q,
    output reg [7:0] busWrData_q,
    output reg busWr_q,
    output reg busRd_q,
    output reg busRmw_q,
    output reg coreRstLevel_q,
    output reg coreXtalLevel_q,
    output reg [31:0] corePinLevel_q,
    output reg [15:0] instr_q,
    output reg [7:0] flashCtrl_q,
    output reg [7:0] flashData_q,
    output reg [FLASH_ADDR_W-1:0] flashAddr_q,
    output reg [7:0] flashScale_q
);
    localparam [3:0] ST_RESET = 4'h0;
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SELDR = 4'h2;
    localparam [3:0] ST_CAPDR = 4'h3;
    localparam [3:0] ST_SHDR = 4'h4;
    localparam [3:0] ST_EX1DR = 4'h5;
    localparam [3:0] ST_PAUDR = 4'h6;
    localparam [3:0] ST_EX2DR = 4'h7;
    localparam [3:0] ST_UPDR = 4'h8;
    localparam [3:0] ST_SELIR = 4'h9;
    localparam [3:0] ST_CAPIR = 4'ha;
    localparam [3:0] ST_SHIR = 4'hb;
    localparam [3:0] ST_EX1IR = 4'hc;
    localparam [3:0] ST_PAUIR = 4'hd;
    localparam [3:0] ST_EX2IR = 4'he;
    localparam [3:0] ST_UPIR = 4'hf;

    // scan length of the register that an instruction selects
    function [6:0] jtbSelLen;
        input [15:0] ir;
        begin
            case (ir)
                `JTB_IR_EXTEST,
                `JTB_IR_SAMPLE: jtbSelLen = `JTB_LEN_BS;
                `JTB_IR_IDCODE: jtbSelLen = `JTB_LEN_ID;
                `JTB_IR_FLCTRL,
                `JTB_IR_FLDATA,
                `JTB_IR_FLADDR,
                `JTB_IR_FLSCALE: jtbSelLen = `JTB_LEN_FLASH;
                default: jtbSelLen = `JTB_LEN_BYP;
            endcase
        end
    endfunction

    // shift one place toward bit 0, new bit enters at the top of the selected length
    function [86:0] jtbShiftDr;
        input [86:0] sr;
        input bitIn;
        input [6:0] len;
        integer i;
        reg [6:0] top;
        begin
            top = len - 7'd1;
            for (i = 0; i < 87; i = i + 1) begin
                if (i == top)
                    jtbShiftDr[i] = bitIn;
                else if (i < 86)
                    jtbShiftDr[i] = sr[i+1];
                else
                    jtbShiftDr[i] = 1'b0;
            end
        end
    endfunction

    // tap state transition on a test clock rising edge
    function [3:0] jtbNext;
        input [3:0] st;
        input m;
        begin
            case (st)
                ST_RESET: jtbNext = m ? ST_RESET : ST_IDLE;
                ST_IDLE: jtbNext = m ? ST_SELDR : ST_IDLE;
                ST_SELDR: jtbNext = m ? ST_SELIR : ST_CAPDR;
                ST_CAPDR: jtbNext = m ? ST_EX1DR : ST_SHDR;
                ST_SHDR: jtbNext = m ? ST_EX1DR : ST_SHDR;
                ST_EX1DR: jtbNext = m ? ST_UPDR : ST_PAUDR;
                ST_PAUDR: jtbNext = m ? ST_EX2DR : ST_PAUDR;
                ST_EX2DR: jtbNext = m ? ST_UPDR : ST_SHDR;
                ST_UPDR: jtbNext = m ? ST_SELDR : ST_IDLE;
                ST_SELIR: jtbNext = m ? ST_RESET : ST_CAPIR;
                ST_CAPIR: jtbNext = m ? ST_EX1IR : ST_SHIR;
                ST_SHIR: jtbNext = m ? ST_EX1IR : ST_SHIR;
                ST_EX1IR: jtbNext = m ? ST_UPIR : ST_PAUIR;
                ST_PAUIR: jtbNext = m ? ST_EX2IR : ST_PAUIR;
                ST_EX2IR: jtbNext = m ? ST_UPIR : ST_SHIR;
                ST_UPIR: jtbNext = m ? ST_SELDR : ST_IDLE;
                default: jtbNext = ST_RESET;
            endcase
        end
    endfunction

    // chain positions of port pin k: output enable, then the pin level just above it
    function integer jtbOeBit;
        input integer k;
        begin
            jtbOeBit = `JTB_BS_PORT0 + 2 * k;
        end
    endfunction

    function integer jtbPinBit;
        input integer k;
        begin
            jtbPinBit = jtbOeBit(k) + 1;
        end
    endfunction

    wire [`JTB_SYNC_W-1:0] syncIn;
    wire [`JTB_SYNC_W-1:0] syncOut;
    wire tckS;
    wire tmsS;
    wire tdiS;
    wire rstPinS;
    wire xtalS;
    wire [31:0] portPinS;

    assign syncIn = {portPinIn, xtalPinIn, rstPinIn, tdi, tms, tck};

    jtb_pin_sync #(
        .W(`JTB_SYNC_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .asyncIn(syncIn),
        .syncOut_q(syncOut)
    );

    assign tckS = syncOut[0];
    assign tmsS = syncOut[1];
    assign tdiS = syncOut[2];
    assign rstPinS = syncOut[3];
    assign xtalS = syncOut[4];
    assign portPinS = syncOut[36:5];

    reg tckPrev_q;
    reg [3:0] state_q;
    reg [15:0] irShift_q;
    reg [86:0] drShift_q;
    reg [86:0] bsUpd_q;
    reg [86:0] capVec;
    reg [86:0] drCapture;

    wire tckRise;
    wire tckFall;
    wire [6:0] selLen;
    wire extest;
    wire bsSelected;
    wire flashWrite;
    wire [`JTB_FL_WD_HI:0] flashWd;

    // edges found from the synchronised copy; tck is only an input here
    assign tckRise = tckS & ~tckPrev_q;
    assign tckFall = ~tckS & tckPrev_q;
    assign selLen = jtbSelLen(instr_q);
    assign extest = (instr_q == `JTB_IR_EXTEST);
    assign bsSelected = extest | (instr_q == `JTB_IR_SAMPLE);
    assign flashWrite = (drShift_q[`JTB_FL_OP_HI:`JTB_FL_OP_LO] == `JTB_FL_OP_WRITE);
    assign flashWd = drShift_q[`JTB_FL_WD_HI:0];

    // boundary capture image, lsb first on every bus
    always @* begin : capture_build
        integer k;
        k = 0;
        capVec = 87'h0;
        capVec[`JTB_BS_RSTOE] = coreRstDriveEn;
        capVec[`JTB_BS_RSTPIN] = rstPinS;
        capVec[`JTB_BS_XTAL] = xtalS;
        capVec[`JTB_BS_PULLUP] = corePullupEn;
        capVec[`JTB_BS_ADDR_HI:`JTB_BS_ADDR_LO] = coreBusAddr;
        capVec[`JTB_BS_DATA_HI:`JTB_BS_DATA_LO] = busRdData;
        capVec[`JTB_BS_WR] = coreBusWr;
        capVec[`JTB_BS_RD] = coreBusRd;
        capVec[`JTB_BS_RMW] = coreBusRmw;
        for (k = 0; k < `JTB_PORT_PINS; k = k + 1) begin
            capVec[jtbOeBit(k)] = corePortOe[k];
            capVec[jtbPinBit(k)] = portPinS[k];
        end
    end

    // value loaded in capture-dr; flash registers read back right-justified, busy low
    always @* begin
        drCapture = 87'h0;
        case (instr_q)
            `JTB_IR_EXTEST,
            `JTB_IR_SAMPLE: drCapture = capVec;
            `JTB_IR_IDCODE: drCapture[31:0] = ID_VALUE;
            `JTB_IR_FLCTRL: drCapture[8:1] = flashCtrl_q;
            `JTB_IR_FLDATA: drCapture[8:1] = flashData_q;
            `JTB_IR_FLADDR: drCapture[FLASH_ADDR_W:1] = flashAddr_q;
            `JTB_IR_FLSCALE: drCapture[8:1] = flashScale_q;
            default: drCapture = 87'h0;
        endcase
    end

    // tap controller and scan registers, stepped on test clock edges
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tckPrev_q <= 1'b0;
            state_q <= ST_RESET;
            irShift_q <= 16'h0000;
            instr_q <= `JTB_IR_RESET;
            drShift_q <= 87'h0;
            bsUpd_q <= 87'h0;
            flashCtrl_q <= 8'h00;
            flashData_q <= 8'h00;
            flashAddr_q <= {FLASH_ADDR_W{1'b0}};
            flashScale_q <= 8'h00;
            tdo_q <= 1'b0;
            tdoOe_n_q <= 1'b1;
        end else begin
            tckPrev_q <= tckS;
            if (tckRise) begin
                state_q <= jtbNext(state_q, tmsS);
                case (state_q)
                    ST_RESET: instr_q <= `JTB_IR_RESET;
                    ST_CAPIR: irShift_q <= `JTB_IR_CAPTURE;
                    ST_SHIR: irShift_q <= {tdiS, irShift_q[15:1]};
                    ST_UPIR: instr_q <= irShift_q;
                    ST_CAPDR: drShift_q <= drCapture;
                    ST_SHDR: drShift_q <= jtbShiftDr(drShift_q, tdiS, selLen);
                    ST_UPDR: begin
                        // sample/preload fills the latches too, pins follow only in extest
                        if (bsSelected)
                            bsUpd_q <= drShift_q;
                        // write data is left-justified; poll and read change nothing
                        if (flashWrite) begin
                            case (instr_q)
                                `JTB_IR_FLCTRL: flashCtrl_q <= flashWd[17:10];
                                `JTB_IR_FLDATA: flashData_q <= flashWd[17:10];
                                `JTB_IR_FLADDR: flashAddr_q <= flashWd[17:18-FLASH_ADDR_W];
                                `JTB_IR_FLSCALE: flashScale_q <= flashWd[17:10];
                                default: flashCtrl_q <= flashCtrl_q;
                            endcase
                        end
                    end
                    default: irShift_q <= irShift_q;
                endcase
            end
            // tdo changes on the falling edge so the far end samples it stably
            if (tckFall) begin
                if (state_q == ST_SHIR) begin
                    tdo_q <= irShift_q[0];
                    tdoOe_n_q <= 1'b0;
                end else if (state_q == ST_SHDR) begin
                    tdo_q <= drShift_q[0];
                    tdoOe_n_q <= 1'b0;
                end else begin
                    tdoOe_n_q <= 1'b1;
                end
            end
        end
    end

    // pin and bus drive; one ref_clk of latency so every output is a flop
    always @(posedge ref_clk or negedge rstn) begin : drive
        integer k;
        if (!rstn) begin
            rstPinOut_q <= 1'b0;
            rstPinOe_n_q <= 1'b1;
            pullupEn_q <= 1'b0;
            busAddr_q <= 8'h00;
            busWrData_q <= 8'h00;
            busWr_q <= 1'b0;
            busRd_q <= 1'b0;
            busRmw_q <= 1'b0;
            portPinOut_q <= 32'h00000000;
            portPinOe_n_q <= 32'hffffffff;
            coreRstLevel_q <= 1'b1;
            coreXtalLevel_q <= 1'b1;
            corePinLevel_q <= 32'hffffffff;
        end else if (extest) begin
            rstPinOe_n_q <= ~bsUpd_q[`JTB_BS_RSTOE];
            rstPinOut_q <= bsUpd_q[`JTB_BS_RSTPIN];
            pullupEn_q <= bsUpd_q[`JTB_BS_PULLUP];
            busAddr_q <= bsUpd_q[`JTB_BS_ADDR_HI:`JTB_BS_ADDR_LO];
            busWrData_q <= bsUpd_q[`JTB_BS_DATA_HI:`JTB_BS_DATA_LO];
            busWr_q <= bsUpd_q[`JTB_BS_WR];
            busRd_q <= bsUpd_q[`JTB_BS_RD];
            busRmw_q <= bsUpd_q[`JTB_BS_RMW];
            for (k = 0; k < `JTB_PORT_PINS; k = k + 1) begin
                portPinOe_n_q[k] <= ~bsUpd_q[jtbOeBit(k)];
                portPinOut_q[k] <= bsUpd_q[jtbPinBit(k)];
            end
            coreRstLevel_q <= 1'b1;
            coreXtalLevel_q <= 1'b1;
            corePinLevel_q <= 32'hffffffff;
        end else begin
            // reset pin is open-drain outside extest: here it only pulls low, extest can drive it high
            rstPinOe_n_q <= ~coreRstDriveEn;
            rstPinOut_q <= 1'b0;
            pullupEn_q <= corePullupEn;
            busAddr_q <= coreBusAddr;
            busWrData_q <= coreBusWrData;
            busWr_q <= coreBusWr;
            busRd_q <= coreBusRd;
            busRmw_q <= coreBusRmw;
            portPinOe_n_q <= ~corePortOe;
            portPinOut_q <= corePortOut;
            coreRstLevel_q <= rstPinS;
            coreXtalLevel_q <= xtalS;
            corePinLevel_q <= portPinS;
        end
    end
endmodule // jtb_tap_core

// ===== jtb_tap_checker.sv
/* Concurrent checks on the tap and its core-side outputs.
 * Assumes binding to jtb_tap_core, with tck far below ref_clk. */
`timescale 1ns/10ps
module jtb_tap_checker (
    input wire ref_clk,
    input wire rstn,
    input wire tck,
    input wire tdo_q,
    input wire [15:0] instr_q,
    input wire corePullupEn,
    input wire [31:0] corePortOut,
    input wire [31:0] corePortOe,
    input wire [7:0] coreBusAddr,
    input wire [7:0] coreBusWrData,
    input wire coreBusWr,
    input wire coreBusRd,
    input wire coreBusRmw,
    input wire pullupEn_q,
    input wire [7:0] busAddr_q,
    input wire [7:0] busWrData_q,
    input wire busWr_q,
    input wire busRd_q,
    input wire busRmw_q,
    input wire [31:0] portPinOut_q,
    input wire [31:0] portPinOe_n_q,
    input wire coreRstLevel_q,
    input wire coreXtalLevel_q,
    input wire [31:0] corePinLevel_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // two cycles in a mode, so the output mux has caught up
    sequence s_ext;
        instr_q == 16'h0000 ##1 instr_q == 16'h0000;
    endsequence
    sequence s_norm;
        instr_q != 16'h0000 ##1 instr_q != 16'h0000;
    endsequence
    property p_tdoFall;
        $changed(tdo_q) |-> !$past(tck, 2);
    endproperty
    a_tdoFall: assert property (p_tdoFall) else $error("tdo moved with tck high");
    property p_irRise;
        $changed(instr_q) |-> $past(tck, 2);
    endproperty
    a_irRise: assert property (p_irRise) else $error("instruction moved with tck low");
    property p_extLevels;
        s_ext |-> coreRstLevel_q && coreXtalLevel_q && (&corePinLevel_q);
    endproperty
    a_extLevels: assert property (p_extLevels) else $error("core levels not one");
    property p_passBus;
        s_norm |-> busAddr_q == $past(coreBusAddr) && busWrData_q == $past(coreBusWrData);
    endproperty
    a_passBus: assert property (p_passBus) else $error("bus not from core");
    property p_passStrobe;
        s_norm |-> {busWr_q, busRd_q, busRmw_q} == $past({coreBusWr, coreBusRd, coreBusRmw});
    endproperty
    a_passStrobe: assert property (p_passStrobe) else $error("strobes not from core");
    property p_passPort;
        s_norm |-> portPinOut_q == $past(corePortOut) && portPinOe_n_q == ~$past(corePortOe);
    endproperty
    a_passPort: assert property (p_passPort) else $error("ports not from core");
    property p_passPull;
        s_norm |-> pullupEn_q == $past(corePullupEn);
    endproperty
    a_passPull: assert property (p_passPull) else $error("pullup not from core");
    property p_extHold;
        instr_q == 16'h0000 && $changed({busAddr_q, busWrData_q, portPinOut_q}) |-> $past(tck, 2);
    endproperty
    a_extHold: assert property (p_extHold) else $error("pins moved without update");
endmodule // jtb_tap_checker

bind jtb_tap_core jtb_tap_checker u_chk (.ref_clk(ref_clk), .rstn(rstn), .tck(tck), .tdo_q(tdo_q),
    .instr_q(instr_q), .corePullupEn(corePullupEn), .corePortOut(corePortOut), .corePortOe(corePortOe),
    .coreBusAddr(coreBusAddr), .coreBusWrData(coreBusWrData), .coreBusWr(coreBusWr), .coreBusRd(coreBusRd),
    .coreBusRmw(coreBusRmw), .pullupEn_q(pullupEn_q), .busAddr_q(busAddr_q), .busWrData_q(busWrData_q),
    .busWr_q(busWr_q), .busRd_q(busRd_q), .busRmw_q(busRmw_q), .portPinOut_q(portPinOut_q),
    .portPinOe_n_q(portPinOe_n_q), .coreRstLevel_q(coreRstLevel_q), .coreXtalLevel_q(coreXtalLevel_q),
    .corePinLevel_q(corePinLevel_q));

// ===== jtb_jtag_host.sv
/* Test controller model driving tck, tms and tdi, reading tdo.
 * Assumes the tap samples on tck rise; tck rests low between frames. */
`timescale 1ns/10ps
module jtb_jtag_host (
    output reg tck = 1'b0,
    output reg tms = 1'b1,
    output reg tdi = 1'b0,
    input wire tdo
);
    // tdo sampled just before the rise that shifts it out
    task step(input m, input dIn, output o);
        begin
            tms = m;
            tdi = dIn;
            #62.5;
            o = tdo;
            tck = 1'b1;
            #62.5;
            tck = 1'b0;
        end
    endtask
    // five ones reach reset from any state; tdi toggles as it is unused
    task reset_tap;
        integer i;
        reg o;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                step(i < 5, ~tdi, o);
            end
        end
    endtask
    task scan(input ir, input [86:0] din, input integer n, output [86:0] dout);
        integer i;
        reg o;
        begin
            dout = 87'h0;
            step(1'b1, ~tdi, o);
            if (ir) begin
                step(1'b1, ~tdi, o);
            end
            step(1'b0, ~tdi, o);
            step(1'b0, ~tdi, o);
            for (i = 0; i < n; i = i + 1) begin
                step(i == n - 1, din[i], o);
                dout[i] = o;
            end
            step(1'b1, ~tdi, o);
            step(1'b0, ~tdi, o);
        end
    endtask
endmodule // jtb_jtag_host

// ===== test_jtag_tap_boundary_scan.sv
/* Self-checking bench for jtb_tap_core with random core-side traffic.
 * Assumes the checker and jtb_jtag_host are compiled before it. */
`timescale 1ns/10ps
module test_jtag_tap_boundary_scan;
    localparam [31:0] ID = 32'h5a3c0f01; // arbitrary value
    reg ref_clk = 1'b0;
    reg rstn = 1'b0;
    reg hold = 1'b0;
    reg oePrev = 1'b1;
    integer oeDrops = 0;
    reg [126:0] inp = 127'h0;
    reg [127:0] r;
    reg [31:0] inSeed = 32'he3fc5293;
    reg [31:0] seed = 32'he3fc5293;
    integer n_mismatch = 0;
    integer check_count = 0;
    integer i;
    reg [86:0] pat;
    reg [86:0] d;
    reg [15:0] val;
    wire tck, tms, tdi, tdo, tdoOe_n, rstOut, rstOe_n, pullupEn, busWr, busRd, busRmw, rstLvl, xtalLvl;
    wire [31:0] portOut, portOe_n, pinLvl;
    wire [7:0] busAddr, busWrData, flCtrl, flData, flScale;
    wire [15:0] instr, flAddr;
    jtb_tap_core #(.ID_VALUE(ID)) dut_u (
        .ref_clk(ref_clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo_q(tdo), .tdoOe_n_q(tdoOe_n),
        .rstPinIn(inp[0]), .rstPinOut_q(rstOut), .rstPinOe_n_q(rstOe_n), .xtalPinIn(inp[1]),
        .portPinIn(inp[33:2]), .portPinOut_q(portOut), .portPinOe_n_q(portOe_n), .coreRstDriveEn(inp[34]),
        .corePullupEn(inp[35]), .corePortOut(inp[67:36]), .corePortOe(inp[99:68]), .coreBusAddr(inp[107:100]),
        .coreBusWrData(inp[115:108]), .coreBusWr(inp[116]), .coreBusRd(inp[117]), .coreBusRmw(inp[118]),
        .busRdData(inp[126:119]), .pullupEn_q(pullupEn), .busAddr_q(busAddr), .busWrData_q(busWrData),
        .busWr_q(busWr), .busRd_q(busRd), .busRmw_q(busRmw), .coreRstLevel_q(rstLvl), .coreXtalLevel_q(xtalLvl),
        .corePinLevel_q(pinLvl), .instr_q(instr), .flashCtrl_q(flCtrl), .flashData_q(flData),
        .flashAddr_q(flAddr), .flashScale_q(flScale)
    );
    jtb_jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    always #5 ref_clk = ~ref_clk;
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // hold freezes core and pins so a capture sees known values
    always @(posedge ref_clk) begin
        if (!hold) begin
            repeat (4) begin
                inSeed = lfsr(inSeed);
                r = {r[95:0], inSeed};
            end
            inp <= r[126:0];
        end
    end
    // counts each time tdo starts driving, once per shift phase
    always @(posedge ref_clk) begin
        oePrev <= tdoOe_n;
        if (oePrev === 1'b1 && tdoOe_n === 1'b0) begin
            oeDrops <= oeDrops + 1;
        end
    end
    function [86:0] bsExp(input [126:0] v);
        integer k;
        begin
            bsExp = {64'h0, v[118:116], v[126:119], v[107:100], v[35], v[1], v[0], v[34]};
            for (k = 0; k < 32; k = k + 1) begin
                bsExp[23 + 2 * k] = v[68 + k];
                bsExp[24 + 2 * k] = v[2 + k];
            end
        end
    endfunction
    // pins in chain order; bit 2 has no update stage
    function [86:0] obs(input dummy);
        integer k;
        begin
            obs = {64'h0, busRmw, busRd, busWr, busWrData, busAddr, pullupEn, 1'b0, rstOut, ~rstOe_n};
            for (k = 0; k < 32; k = k + 1) begin
                obs[23 + 2 * k] = ~portOe_n[k];
                obs[24 + 2 * k] = portOut[k];
            end
        end
    endfunction
    task chk(input [86:0] got, input [86:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rndPat(output [86:0] p);
        begin
            repeat (3) begin
                seed = lfsr(seed);
                p = {p[54:0], seed};
            end
        end
    endtask
    task ldIr(input [15:0] code);
        reg [86:0] q;
        integer n0;
        begin
            n0 = oeDrops;
            host.scan(1'b1, 87'(code), 16, q);
            chk(87'(q[15:0]), 87'h1);
            chk(87'(instr), 87'(code));
            chk(87'(oeDrops - n0), 87'h1);
            chk(87'(tdoOe_n), 87'h1);
        end
    endtask
    task end_sim;
        begin
            if (n_mismatch == 0 && check_count > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    initial begin
        #500000;
        n_mismatch = n_mismatch + 1;
        end_sim;
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk(87'(instr), 87'h0);
        chk(obs(1'b0), 87'h0);
        chk(87'({rstLvl, xtalLvl, pinLvl}), {53'h0, {34{1'b1}}});
        host.reset_tap;
        for (i = 0; i < 2; i = i + 1) begin
            ldIr(i ? 16'h1234 : 16'hffff);
            rndPat(pat);
            host.scan(1'b0, pat, 8, d);
            chk(87'(d[7:0]), 87'({pat[6:0], 1'b0}));
        end
        host.reset_tap;
        chk(87'(instr), 87'h0);
        ldIr(16'h0004);
        rndPat(pat);
        host.scan(1'b0, pat, 32, d);
        chk(87'(d[31:0]), 87'(ID));
        for (i = 0; i < 4; i = i + 1) begin
            ldIr(16'h0082 + i[15:0]);
            rndPat(pat);
            val = (i == 2) ? pat[15:0] : {8'h0, pat[7:0]};
            host.scan(1'b0, {67'h0, 2'b11, (i == 2) ? {val, 2'b00} : {val[7:0], 10'h0}}, 20, d);
            // read opcode with inverted data must leave the register alone
            host.scan(1'b0, {67'h0, 2'b10, ~((i == 2) ? {val, 2'b00} : {val[7:0], 10'h0})}, 20, d);
            chk(87'(d[19:0]), 87'({val, 1'b0}));
            chk(87'(i == 0 ? flCtrl : i == 1 ? flData : i == 2 ? flAddr : flScale), 87'(val));
        end
        @(posedge ref_clk);
        hold <= 1'b1;
        // keep the link off the sampling edge
        #1;
        ldIr(16'h0002);
        rndPat(pat);
        host.scan(1'b0, pat, 87, d);
        chk(d, bsExp(inp));
        chk(87'(busAddr), 87'(inp[107:100]));
        ldIr(16'h0000);
        chk(obs(1'b0), pat & ~87'h4);
        chk(87'({rstLvl, xtalLvl, pinLvl}), {53'h0, {34{1'b1}}});
        rndPat(pat);
        host.scan(1'b0, pat, 87, d);
        chk(d, bsExp(inp));
        chk(obs(1'b0), pat & ~87'h4);
        end_sim;
    end
endmodule // test_jtag_tap_boundary_scan
